// ==== design/adcrs_conv_engine.sv ====
// Conversion sequencer: one sample or a sum of sixteen
`timescale 1ns/1ps
module adcrs_conv_engine (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  adcrs_conv_if.engine     cif,
  output logic             sample_req,
  input  wire logic [11:0] sample_data,
  input  wire logic        sample_valid
);
  adcrs_pkg::adcrs_state_e state_reg;
  logic [3:0]              cnt_reg;
  logic [15:0]             sum_reg;
  logic                    acc_reg;
  logic [15:0]             sum_next;

  assign sum_next = sum_reg + {4'h0, sample_data};

  // Sequencer; abort wins so a disabled converter never reports a result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= adcrs_pkg::ADCRS_IDLE;
      cnt_reg    <= adcrs_pkg::RST_NIB;
      sum_reg    <= 16'h0000;
      acc_reg    <= 1'b0;
      sample_req <= 1'b0;
      cif.busy   <= 1'b0;
      cif.done   <= 1'b0;
      cif.result <= 16'h0000;
    end else begin
      cif.done   <= 1'b0;
      sample_req <= 1'b0;
      if (cif.abort) begin
        state_reg <= adcrs_pkg::ADCRS_IDLE;
        cif.busy  <= 1'b0;
      end else begin
        unique case (state_reg)
          adcrs_pkg::ADCRS_IDLE: begin
            if (cif.start) begin
              state_reg <= adcrs_pkg::ADCRS_SAMPLE;
              cnt_reg   <= adcrs_pkg::RST_NIB;
              sum_reg   <= 16'h0000;
              acc_reg   <= cif.accumulate;
              cif.busy  <= 1'b1;
            end
          end
          adcrs_pkg::ADCRS_SAMPLE: begin
            sample_req <= 1'b1;
            state_reg  <= adcrs_pkg::ADCRS_WAIT;
          end
          adcrs_pkg::ADCRS_WAIT: begin
            if (sample_valid) begin
              sum_reg <= sum_next;
              if (!acc_reg || cnt_reg == adcrs_pkg::ACC_LAST) begin
                state_reg  <= adcrs_pkg::ADCRS_IDLE;
                cif.busy   <= 1'b0;
                cif.done   <= 1'b1;
                cif.result <= sum_next;
              end else begin
                cnt_reg   <= cnt_reg + 4'h1;
                state_reg <= adcrs_pkg::ADCRS_SAMPLE;
              end
            end
          end
        endcase
      end
    end
  end

  // A finished accumulation has taken exactly sixteen samples
  a_acc_sixteen: assert property (@(posedge aclk) disable iff (!aresetn)
    cif.done && acc_reg |-> $past(cnt_reg) == adcrs_pkg::ACC_LAST)
    else $error("accumulation ended before sixteen samples");
  a_done_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    cif.done |-> !cif.busy && !sample_req)
    else $error("busy still set when result delivered");
endmodule

// ==== design/adcrs_conv_if.sv ====
// Handshake between register front end and conversion sequencer
`timescale 1ns/1ps
interface adcrs_conv_if;
  logic        start;
  logic        abort;
  logic        accumulate;
  logic        busy;
  logic        done;
  logic [15:0] result;
  modport ctrl   (output start, output abort, output accumulate,
                  input busy, input done, input result);
  modport engine (input start, input abort, input accumulate,
                  output busy, output done, output result);
endinterface

// ==== design/adcrs_pkg.sv ====
// Constants and types shared by the converter control block
package adcrs_pkg;
  // Byte addresses of the word-aligned registers
  localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
  localparam logic [7:0] ADDR_RES_LOW  = 8'h08;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_SENSOR   = 8'h10;
  localparam logic [7:0] ADDR_PIN_SEL  = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_MASK     = 8'h1C;
  // Field positions in conv_control_a
  localparam int CA_START = 7;
  localparam int CA_BUSY  = 6;
  localparam int CA_EN    = 5;
  localparam int CA_FMT   = 4;
  // Field positions in conv_control_b and sensor_current_control
  localparam int CB_SRC_LSB = 5;
  localparam int SC_ACC     = 5;
  localparam int SC_UNUSED  = 4;
  // Status bits: conversion finished, start refused while busy
  localparam int ST_DONE    = 0;
  localparam int ST_REFUSED = 1;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB  = 4'h0;
  // Input source codes
  localparam logic [2:0] SRC_EXT  = 3'h0;
  localparam logic [2:0] SRC_BATT = 3'h4;
  // Counter value of the last of the sixteen samples summed in accumulate mode
  localparam logic [3:0] ACC_LAST = 4'hF;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ADCRS_IDLE, ADCRS_SAMPLE, ADCRS_WAIT} adcrs_state_e;
endpackage

// ==== design/adcrs_top.sv ====
// Converter control: registers, source routing, pin takeover, result layout
//
// Behaviour
// - One shared converter; only one source routed at a time, 12-bit result.
// - Four external channels and four internal signals, chosen by two fields.
// - Input-source field in control B picks internal signal or external channel.
// - 4-bit channel field in control A picks the external pin.
// - Accumulate mode: sum bits 15:8 in high register, 7:0 in low.
// - Single, format clear: bits 11:4 high, bits 3:0 in low 7:4.
// - Single, format set: bits 11:8 in high 3:0, bits 7:0 low.
// - Result bits unused by the current layout read zero.
// - While converter disabled, result registers keep their contents.
// - Pin taken as analog input loses its digital function.
// - Pin taken as analog input has its pull-high disconnected.
// - Start bit written high then low begins a conversion.
// - Busy flag set when conversion starts, cleared when it completes.
// - Accumulate mode sums sixteen conversions, then clears busy and interrupts.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module adcrs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             sample_req,
  input  wire logic [11:0] sample_data,
  input  wire logic        sample_valid,
  output logic [3:0]       ext_channel_route,
  output logic [3:0]       int_signal_route,
  output logic [3:0]       pin_digital_en,
  input  wire logic [3:0]  pullup_req,
  output logic [3:0]       pullup_en
);
  adcrs_conv_if cif ();

  logic [7:0]  ctrl_a_reg;
  logic [7:0]  ctrl_b_reg;
  logic [7:0]  sensor_reg;
  logic [3:0]  pin_analog_reg;
  logic [7:0]  res_low_reg;
  logic [7:0]  res_high_reg;
  logic [1:0]  status_reg;
  logic [1:0]  status_next;
  logic [1:0]  mask_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic        start_go;
  logic        start_refused;
  logic        rd_status;
  logic [7:0]  rd_byte;
  logic        rd_ok;
  logic [15:0] fmt_word;

  // Layout of the converted value in the high/low result pair
  function automatic logic [15:0] fmt_result(input logic [15:0] raw, input logic acc,
                                             input logic fmt);
    if (acc) begin
      fmt_result = raw;
    end else if (fmt) begin
      fmt_result = {4'h0, raw[11:0]};
    end else begin
      fmt_result = {raw[11:0], 4'h0};
    end
  endfunction

  // Two-bit index to one-hot enable
  function automatic logic [3:0] onehot4(input logic [1:0] sel);
    onehot4 = 4'h1 << sel;
  endfunction

  // Write handshake: address and data taken together, response follows
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= adcrs_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr[7:5] == 3'h0 && s_axi_awaddr[1:0] == 2'h0)
                        ? adcrs_pkg::RESP_OKAY : adcrs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Start fires when a write drops a set start bit; needs converter enabled
  assign start_go = wr_fire && s_axi_wstrb[0] && s_axi_awaddr == adcrs_pkg::ADDR_CTRL_A
                    && ctrl_a_reg[adcrs_pkg::CA_START] && !s_axi_wdata[adcrs_pkg::CA_START]
                    && s_axi_wdata[adcrs_pkg::CA_EN] && !cif.busy;
  assign start_refused = wr_fire && s_axi_wstrb[0] && s_axi_awaddr == adcrs_pkg::ADDR_CTRL_A
                         && ctrl_a_reg[adcrs_pkg::CA_START] && !s_axi_wdata[adcrs_pkg::CA_START]
                         && cif.busy;
  assign cif.start      = start_go;
  assign cif.accumulate = sensor_reg[adcrs_pkg::SC_ACC];
  // A write that enables and starts at once must not be cancelled by the old enable
  assign cif.abort      = !ctrl_a_reg[adcrs_pkg::CA_EN] && !start_go;

  // Software-written registers; busy bit is never stored here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_reg     <= adcrs_pkg::RST_BYTE;
      ctrl_b_reg     <= adcrs_pkg::RST_BYTE;
      sensor_reg     <= adcrs_pkg::RST_BYTE;
      pin_analog_reg <= adcrs_pkg::RST_NIB;
      mask_reg       <= 2'h0;
    end else if (wr_fire && s_axi_wstrb[0]) begin
      unique case (s_axi_awaddr)
        adcrs_pkg::ADDR_CTRL_A: begin
          ctrl_a_reg <= s_axi_wdata[7:0] & 8'hBF;
        end
        adcrs_pkg::ADDR_CTRL_B: begin
          ctrl_b_reg <= s_axi_wdata[7:0];
        end
        adcrs_pkg::ADDR_SENSOR: begin
          sensor_reg <= s_axi_wdata[7:0] & 8'hEF;
        end
        adcrs_pkg::ADDR_PIN_SEL: begin
          pin_analog_reg <= s_axi_wdata[3:0];
        end
        adcrs_pkg::ADDR_MASK: begin
          mask_reg <= s_axi_wdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Result pair is loaded in one edge so software never sees a mix
  assign fmt_word = fmt_result(cif.result, sensor_reg[adcrs_pkg::SC_ACC],
                               ctrl_a_reg[adcrs_pkg::CA_FMT]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_low_reg  <= adcrs_pkg::RST_BYTE;
      res_high_reg <= adcrs_pkg::RST_BYTE;
    end else if (cif.done && ctrl_a_reg[adcrs_pkg::CA_EN]) begin
      res_high_reg <= fmt_word[15:8];
      res_low_reg  <= fmt_word[7:0];
    end
  end

  // Source routing: internal signal and external pin are never both on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_channel_route <= adcrs_pkg::RST_NIB;
      int_signal_route  <= adcrs_pkg::RST_NIB;
    end else begin
      ext_channel_route <= adcrs_pkg::RST_NIB;
      int_signal_route  <= adcrs_pkg::RST_NIB;
      if (ctrl_a_reg[adcrs_pkg::CA_EN]) begin
        if (ctrl_b_reg[7:5] == adcrs_pkg::SRC_EXT || ctrl_b_reg[7:5] > adcrs_pkg::SRC_BATT) begin
          if (ctrl_a_reg[3:2] == 2'h0) begin
            ext_channel_route <= onehot4(ctrl_a_reg[1:0]);
          end
        end else begin
          int_signal_route <= onehot4(2'(ctrl_b_reg[7:5] - 3'h1));
        end
      end
    end
  end

  // Pin takeover: analog pins drop digital function and pull-high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_digital_en <= 4'hF;
      pullup_en      <= adcrs_pkg::RST_NIB;
    end else begin
      pin_digital_en <= ~pin_analog_reg;
      pullup_en      <= pullup_req & ~pin_analog_reg;
    end
  end

  // Sticky status; a set in the clearing read cycle survives
  assign rd_status = rd_fire && s_axi_araddr == adcrs_pkg::ADDR_STATUS;
  always_comb begin
    status_next = rd_status ? 2'h0 : status_reg;
    if (cif.done) begin
      status_next[adcrs_pkg::ST_DONE] = 1'b1;
    end
    if (start_refused) begin
      status_next[adcrs_pkg::ST_REFUSED] = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 2'h0;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq        <= |(status_next & mask_reg);
    end
  end

  // Read data selection; unused bit positions read zero
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      adcrs_pkg::ADDR_CTRL_A: begin
        rd_byte = {ctrl_a_reg[7], cif.busy, ctrl_a_reg[5:0]};
      end
      adcrs_pkg::ADDR_CTRL_B: begin
        rd_byte = ctrl_b_reg;
      end
      adcrs_pkg::ADDR_RES_LOW: begin
        rd_byte = res_low_reg;
      end
      adcrs_pkg::ADDR_RES_HIGH: begin
        rd_byte = res_high_reg;
      end
      adcrs_pkg::ADDR_SENSOR: begin
        rd_byte = sensor_reg;
      end
      adcrs_pkg::ADDR_PIN_SEL: begin
        rd_byte = {4'h0, pin_analog_reg};
      end
      adcrs_pkg::ADDR_STATUS: begin
        rd_byte = {6'h00, status_reg};
      end
      adcrs_pkg::ADDR_MASK: begin
        rd_byte = {6'h00, mask_reg};
      end
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  // Read channel: address taken, data one cycle later, held until rready
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= adcrs_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? adcrs_pkg::RESP_OKAY : adcrs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  adcrs_conv_engine u_engine (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .cif          (cif),
    .sample_req   (sample_req),
    .sample_data  (sample_data),
    .sample_valid (sample_valid)
  );

  // Start write leads to busy and then a sample request
  sequence s_start_seen;
    start_go ##1 cif.busy;
  endsequence
  sequence s_sample_asked;
    cif.busy ##1 sample_req;
  endsequence
  property p_start_flow;
    @(posedge aclk) disable iff (!aresetn)
      start_go |=> s_sample_asked;
  endproperty
  a_start_flow: assert property (p_start_flow)
    else $error("start did not raise busy then request a sample");
  a_start_seq: assert property (@(posedge aclk) disable iff (!aresetn)
    s_start_seen |=> sample_req)
    else $error("sample request missing after start");
  a_hold_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_a_reg[adcrs_pkg::CA_EN] |=> $stable(res_low_reg) && $stable(res_high_reg))
    else $error("result changed while converter disabled");
  a_acc_layout: assert property (@(posedge aclk) disable iff (!aresetn)
    cif.done && ctrl_a_reg[adcrs_pkg::CA_EN] && sensor_reg[adcrs_pkg::SC_ACC]
    |=> {res_high_reg, res_low_reg} == $past(cif.result))
    else $error("accumulated sum not stored in full");
  a_left_layout: assert property (@(posedge aclk) disable iff (!aresetn)
    cif.done && ctrl_a_reg[adcrs_pkg::CA_EN] && !sensor_reg[adcrs_pkg::SC_ACC]
    && !ctrl_a_reg[adcrs_pkg::CA_FMT]
    |=> res_low_reg[3:0] == 4'h0 && res_high_reg == $past(cif.result[11:4]))
    else $error("left-aligned layout wrong");
  a_right_layout: assert property (@(posedge aclk) disable iff (!aresetn)
    cif.done && ctrl_a_reg[adcrs_pkg::CA_EN] && !sensor_reg[adcrs_pkg::SC_ACC]
    && ctrl_a_reg[adcrs_pkg::CA_FMT]
    |=> res_high_reg[7:4] == 4'h0 && res_low_reg == $past(cif.result[7:0]))
    else $error("right-aligned layout wrong");
  a_one_source: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0({ext_channel_route, int_signal_route}))
    else $error("more than one source routed");
  a_pullup_cut: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 ((pullup_en & $past(pin_analog_reg)) == 4'h0
    && (pin_digital_en & $past(pin_analog_reg)) == 4'h0))
    else $error("analog pin still has digital function or pull-high");
  a_irq_done: assert property (@(posedge aclk) disable iff (!aresetn)
    cif.done && mask_reg[adcrs_pkg::ST_DONE] |=> irq && status_reg[adcrs_pkg::ST_DONE])
    else $error("completion did not raise interrupt");
  a_refused_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    start_refused |=> status_reg[adcrs_pkg::ST_REFUSED])
    else $error("refused start not recorded");
  a_status_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_status && !cif.done && !start_refused |=> status_reg == 2'h0)
    else $error("status read did not clear");
  a_route_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_a_reg[adcrs_pkg::CA_EN] |=> ext_channel_route == 4'h0 && int_signal_route == 4'h0)
    else $error("source routed while converter disabled");
  // Bus answers come exactly one cycle after a transfer is taken
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write not answered in the next cycle");
  a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire |=> s_axi_rvalid && s_axi_arready)
    else $error("read not answered in the next cycle");
endmodule

// ==== verif/test_adc_result_and_input_select.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module test_adc_result_and_input_select;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [2:0]  awprot;
  logic [2:0]  arprot;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic        sample_valid;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [3:0]  pullup_req;
  logic [11:0] sample_data;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic        irq;
  logic        sample_req;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic [3:0]  ext_route;
  logic [3:0]  int_route;
  logic [3:0]  dig_en;
  logic [3:0]  pu_en;
  int          n_mismatch;
  int          compares;
  int          cycles;
  int          serve_dly;
  int          dly_cnt;
  int          sum;
  bit          pend;
  logic [15:0] seed;
  logic [7:0]  exp_lo;
  logic [7:0]  exp_hi;
  logic [31:0] rd_d;
  logic [1:0]  rsp;
  logic [11:0] smp_q[$];

  adcrs_top i_adcrs_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(awprot),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .sample_req(sample_req),
    .sample_data(sample_data), .sample_valid(sample_valid),
    .ext_channel_route(ext_route), .int_signal_route(int_route),
    .pin_digital_en(dig_en), .pullup_req(pullup_req), .pullup_en(pu_en)
  );

  // Free-running 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Analog side stand-in: answers each sample request after serve_dly cycles
  always @(posedge aclk) begin
    if (pend && dly_cnt == 0) begin
      sample_valid <= 1'b1;
      if (smp_q.size() > 0) sample_data <= smp_q.pop_front();
      pend = 1'b0;
    end else begin
      sample_valid <= 1'b0;
      if (pend) dly_cnt--;
    end
    if (sample_req === 1'b1) begin
      pend    = 1'b1;
      dly_cnt = serve_dly;
    end
  end

  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 0);
      summarize();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus write; the leading edge keeps a release and a new request apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 100 && bvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (awready === 1'b1) chk({31'h0, wready}, 32'h1);
    end
    if (i == 100) n_mismatch++;
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 100 && rvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (i == 100) n_mismatch++;
    rd_d = rdata;
    rsp  = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_d, {24'h000000, e});
  endtask

  // Start pulse is two writes: start high, then start low
  task automatic conv(input logic [7:0] c);
    wr(adcrs_pkg::ADDR_CTRL_A, c | 8'h80);
    wr(adcrs_pkg::ADDR_CTRL_A, c);
  endtask

  task automatic wait_idle();
    int i;
    rd(adcrs_pkg::ADDR_CTRL_A);
    for (i = 0; i < 300 && rd_d[6] !== 1'b0; i++) rd(adcrs_pkg::ADDR_CTRL_A);
    if (i == 300) n_mismatch++;
  endtask

  // One single conversion; expected layout worked out from the format bit
  task automatic single(input logic [7:0] c);
    logic [11:0] d;
    seed = lfsr(seed);
    d    = seed[11:0];
    smp_q.push_back(d);
    conv(c);
    rc(adcrs_pkg::ADDR_CTRL_A, c | 8'h40);
    wait_idle();
    exp_hi = c[4] ? {4'h0, d[11:8]} : d[11:4];
    exp_lo = c[4] ? d[7:0] : {d[3:0], 4'h0};
    rc(adcrs_pkg::ADDR_RES_HIGH, exp_hi);
    rc(adcrs_pkg::ADDR_RES_LOW, exp_lo);
  endtask

  task automatic summarize();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {awaddr, araddr, awprot, arprot, awvalid, wvalid, bready, arvalid, rready} = '0;
    {sample_valid, wdata, pullup_req, sample_data} = '0;
    wstrb   = 4'hF;
    seed    = 16'h0035;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, unmapped place, read-only result registers
    for (int a = 0; a < 32; a += 4) rc(8'(a), 8'h00);
    rd(8'h20);
    chk({30'h0, rsp}, {30'h0, adcrs_pkg::RESP_SLVERR});
    chk(rd_d, 32'h0);
    wr(8'h24, 8'hFF);
    chk({30'h0, rsp}, {30'h0, adcrs_pkg::RESP_SLVERR});
    wr(adcrs_pkg::ADDR_RES_LOW, 8'hFF);
    chk({30'h0, rsp}, {30'h0, adcrs_pkg::RESP_OKAY});
    rc(adcrs_pkg::ADDR_RES_LOW, 8'h00);
    // A write with its byte lane off is dropped but still answered
    wstrb <= 4'h0;
    wr(adcrs_pkg::ADDR_MASK, 8'h03);
    wstrb <= 4'hF;
    chk({30'h0, rsp}, {30'h0, adcrs_pkg::RESP_OKAY});
    rc(adcrs_pkg::ADDR_MASK, 8'h00);
    $display("test reset_map done");
    // Pin takeover with random pull-high requests
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      pullup_req <= seed[7:4];
      wr(adcrs_pkg::ADDR_PIN_SEL, {4'h0, seed[3:0]});
      repeat (2) @(posedge aclk);
      chk({28'h0, dig_en}, {28'h0, ~seed[3:0]});
      chk({28'h0, pu_en}, {28'h0, seed[7:4] & ~seed[3:0]});
    end
    $display("test pins done");
    // Every source code against channels in and out of range, pins taken first
    wr(adcrs_pkg::ADDR_PIN_SEL, 8'h0F);
    for (int s = 0; s < 8; s++) begin
      for (int ch = 0; ch < 6; ch++) begin
        seed = lfsr(seed);
        wr(adcrs_pkg::ADDR_CTRL_B, {s[2:0], seed[4:0]});
        wr(adcrs_pkg::ADDR_CTRL_A, 8'h20 | 8'(ch));
        repeat (2) @(posedge aclk);
        chk({28'h0, ext_route}, ((s == 0 || s > 4) && ch < 4) ? 32'h1 << ch : 32'h0);
        chk({28'h0, int_route}, (s > 0 && s < 5) ? 32'h1 << (s - 1) : 32'h0);
        rc(adcrs_pkg::ADDR_CTRL_B, {s[2:0], seed[4:0]});
      end
    end
    wr(adcrs_pkg::ADDR_CTRL_B, 8'h00);
    wr(adcrs_pkg::ADDR_CTRL_A, 8'h03);
    repeat (2) @(posedge aclk);
    chk({24'h0, ext_route, int_route}, 32'h0);
    chk({28'h0, dig_en}, 32'h0);
    $display("test routing done");
    // Single conversions in both formats, sample answers after 20 and after 60 cycles
    wr(adcrs_pkg::ADDR_MASK, 8'h01);
    serve_dly = 20;
    single(8'h22);
    chk({31'h0, irq}, 32'h1);
    rc(adcrs_pkg::ADDR_STATUS, 8'h01);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    serve_dly = 60;
    single(8'h31);
    rc(adcrs_pkg::ADDR_STATUS, 8'h01);
    $display("test single done");
    // Sum of sixteen, with a refused start in mid-run
    wr(adcrs_pkg::ADDR_SENSOR, 8'hFF);
    rc(adcrs_pkg::ADDR_SENSOR, 8'hEF);
    wr(adcrs_pkg::ADDR_SENSOR, 8'h20);
    serve_dly = 0;
    sum = 0;
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      smp_q.push_back(seed[11:0]);
      sum += seed[11:0];
    end
    conv(8'h31);
    conv(8'h31);
    chk({31'h0, irq}, 32'h0);
    wait_idle();
    exp_hi = 8'(sum >> 8);
    exp_lo = 8'(sum);
    rc(adcrs_pkg::ADDR_RES_HIGH, exp_hi);
    rc(adcrs_pkg::ADDR_RES_LOW, exp_lo);
    chk({31'h0, irq}, 32'h1);
    rc(adcrs_pkg::ADDR_STATUS, 8'h03);
    wr(adcrs_pkg::ADDR_SENSOR, 8'h00);
    $display("test accumulate done");
    // Abort by clearing enable, then a start while disabled
    serve_dly = 40;
    smp_q.push_back(12'hABC);
    conv(8'h20);
    wr(adcrs_pkg::ADDR_CTRL_A, 8'h00);
    repeat (2) @(posedge aclk);
    rc(adcrs_pkg::ADDR_CTRL_A, 8'h00);
    repeat (60) @(posedge aclk);
    conv(8'h00);
    rc(adcrs_pkg::ADDR_CTRL_A, 8'h00);
    rc(adcrs_pkg::ADDR_RES_HIGH, exp_hi);
    rc(adcrs_pkg::ADDR_RES_LOW, exp_lo);
    rc(adcrs_pkg::ADDR_STATUS, 8'h00);
    $display("test disable done");
    summarize();
  end
endmodule
